// ==== logic/sync_serial_io_mode.sv ====
// Clocked synchronous serial I/O unit: 8-bit LSB-first shifting with internal or
// external serial clock, transmit, receive and full-duplex modes, AXI4-Lite registers.
// Assumes an external peer on the serial pins and software servicing the interrupt pulse.
//
// How it works
// - Clock select 111 picks external clock pin.
// - Seven internal rates, driven out on clock pin.
// - Serial clock idles high before first edge.
// - Internal clock waits for software buffer service.
// - Output on falling edge, sample on rising.
// - Transmit, receive, duplex chosen by mode field.
// - Start loads buffer, shifts eight bits LSB first.
// - Buffer load empties buffer, interrupts in transmit mode only.
// - Internal transmit halts clock until buffer written.
// - Output keeps previous last bit until falling.
// - Cleared start finishes word; inhibit aborts now.
// - External transmit unserviced sends dummy then stops.
// - Receive eight bits, store, raise full interrupt.
// - Internal receive waits until byte is read.
// - Receive finishes word on stop; inhibit discards.
// - Mode change discards buffer contents.
// - Duplex shifts both ways, interrupts per word.
// - Internal duplex waits for read and write.
// - Duplex stop completes received word first.
// - Final bit held on output after stop.
// - Idle run bit keeps unit alive in idle.
// - Status bit 3 shows transfer in progress.
// - Separate write and read data storage.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sync_serial_io_mode
  import sio_pkg::*;
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] awaddr_in,
  input wire logic awvalid_in,
  output var logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output var logic wready_out,
  output var logic [1:0] bresp_out,
  output var logic bvalid_out,
  input wire logic bready_in,
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  output var logic arready_out,
  output var logic [31:0] rdata_out,
  output var logic [1:0] rresp_out,
  output var logic rvalid_out,
  input wire logic rready_in,
  input wire logic serial_clock_pin_in,
  output var logic serial_clock_pin_out,
  output var logic serial_clock_pin_oe_n_out,
  input wire logic serial_data_in,
  output var logic serial_data_out,
  input wire logic idle_mode_in,
  output var logic serial_interrupt_out
);

  control_t control;
  logic idle_run;
  phase_t phase;
  logic [7:0] tx_buf;
  logic tx_full;
  logic [7:0] rx_buf;
  logic rx_full;
  logic [7:0] shreg;
  logic [2:0] bit_cnt;
  logic active;
  logic dummy_stop;
  logic [7:0] half_cnt;
  logic sclk_prev;
  logic [1:0] pins_sync;
  logic aw_have;
  logic w_have;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Pin inputs pass two flops before any logic looks at them.
  sio_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_in(mclk_in),
    .rst_in(sys_rst_in),
    .async_in({serial_clock_pin_in, serial_data_in}),
    .sync_out(pins_sync)
  );

  wire sclk_s = pins_sync[1];
  wire sdi_s = pins_sync[0];

  // Bus handshake terms.
  wire aw_fire = awvalid_in & awready_out;
  wire w_fire = wvalid_in & wready_out;
  wire wr_go = aw_have & w_have & ~bvalid_out;
  wire b_fire = bvalid_out & bready_in;
  wire ar_fire = arvalid_in & arready_out;
  wire r_fire = rvalid_out & rready_in;
  wire next_aw_have = aw_fire | (aw_have & ~wr_go);
  wire next_w_have = w_fire | (w_have & ~wr_go);
  wire next_rvalid = ar_fire | (rvalid_out & ~r_fire);

  // Write decode; a register only changes when its low byte lane is strobed.
  wire wr_low = wr_go & w_strb[0];
  wire wr_hit = (aw_addr == ADDR_CONTROL) | (aw_addr == ADDR_DATA) | (aw_addr == ADDR_STATUS) |
                (aw_addr == ADDR_BAUD_IDLE);
  wire control_wr = wr_low & (aw_addr == ADDR_CONTROL);
  wire data_wr = wr_low & (aw_addr == ADDR_DATA);
  wire idle_wr = wr_low & (aw_addr == ADDR_BAUD_IDLE);
  wire control_t new_control = control_t'(w_data[7:0]);
  wire mode_change = control_wr & (new_control.mode != control.mode);

  // Read decode; reading the data word consumes the received byte.
  wire rd_hit = (araddr_in == ADDR_CONTROL) | (araddr_in == ADDR_DATA) | (araddr_in == ADDR_STATUS) |
                (araddr_in == ADDR_BAUD_IDLE);
  wire data_rd = ar_fire & (araddr_in == ADDR_DATA);
  wire [7:0] status_byte = STATUS_ONES | {4'h0, active, (phase == ST_SHIFT), 2'h0};
  wire [7:0] baud_idle_byte = BAUD_IDLE_ONES | {1'b0, idle_run, 6'h00};
  wire [7:0] rd_byte = (araddr_in == ADDR_CONTROL) ? control :
                       (araddr_in == ADDR_DATA) ? rx_buf :
                       (araddr_in == ADDR_STATUS) ? status_byte :
                       (araddr_in == ADDR_BAUD_IDLE) ? baud_idle_byte : 8'h00;

  // Mode and clock terms.
  wire ext_clk = (control.clk_sel == CLK_EXTERNAL);
  wire tx_on = (control.mode == MODE_TX) | (control.mode == MODE_TXRX);
  wire rx_on = (control.mode == MODE_RX) | (control.mode == MODE_TXRX);
  wire mode_ok = (control.mode != MODE_RSVD);
  wire halt = idle_mode_in & ~idle_run;
  wire shifting = (phase == ST_SHIFT) & ~halt;

  // Internal half period doubles per select step, giving seven rates from the bus clock.
  wire [7:0] half_len = HALF_BASE << control.clk_sel;
  wire [7:0] half_last = half_len - 8'h01;
  wire tick = shifting & ~ext_clk & (half_cnt == half_last);
  wire int_fall = tick & serial_clock_pin_out;
  wire int_rise = tick & ~serial_clock_pin_out;
  wire ext_fall = shifting & ext_clk & sclk_prev & ~sclk_s;
  wire ext_rise = shifting & ext_clk & ~sclk_prev & sclk_s;
  wire fall_ev = ext_clk ? ext_fall : int_fall;
  wire rise_ev = ext_clk ? ext_rise : int_rise;
  wire [7:0] shifted = {sdi_s, shreg[7:1]};
  wire word_end = rise_ev & (bit_cnt == BITS_LAST);

  // Internal clock paces the next word only once software has serviced the buffer.
  wire tx_ready = ~tx_on | tx_full;
  wire rx_ready = ~rx_on | ~rx_full;
  wire word_ready = ext_clk | (tx_ready & rx_ready);

  // Write address and write data are held separately, so they may arrive in either order.
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      awready_out <= 1'b0;
      wready_out <= 1'b0;
    end else begin
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      awready_out <= ~next_aw_have;
      wready_out <= ~next_w_have;
    end
  end

  // Captured write payload.
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (aw_fire) begin
        aw_addr <= awaddr_in;
      end
      if (w_fire) begin
        w_data <= wdata_in;
        w_strb <= wstrb_in;
      end
    end
  end

  // Write response follows one cycle after both halves are present.
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bvalid_out <= 1'b0;
      bresp_out <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_out <= 1'b1;
      bresp_out <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (b_fire) begin
      bvalid_out <= 1'b0;
    end
  end

  // Read data is registered; unmapped addresses answer zero with a slave error.
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rvalid_out <= 1'b0;
      arready_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
      rresp_out <= RESP_OKAY;
    end else begin
      rvalid_out <= next_rvalid;
      arready_out <= ~next_rvalid;
      if (ar_fire) begin
        rdata_out <= {24'h00_0000, rd_byte};
        rresp_out <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Software-owned settings; the spare bit is kept at zero and bit 0 of the idle word is dropped.
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      control <= CONTROL_RESET;
      idle_run <= IDLE_RUN_RESET;
    end else begin
      if (control_wr) begin
        control <= {new_control.start, new_control.inhibit, new_control.mode, 1'b0, new_control.clk_sel};
      end
      if (idle_wr) begin
        idle_run <= w_data[IDLE_RUN_BIT];
      end
    end
  end

  // Internal divider runs only while shifting, so a wait freezes the clock where it stands.
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      half_cnt <= 8'h00;
    end else if (~shifting | ext_clk | tick) begin
      half_cnt <= 8'h00;
    end else begin
      half_cnt <= half_cnt + 8'h01;
    end
  end

  // Serial clock pin: driven only in internal mode, parked high outside the shift phase.
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      serial_clock_pin_out <= 1'b1;
      serial_clock_pin_oe_n_out <= 1'b1;
      sclk_prev <= 1'b1;
    end else begin
      serial_clock_pin_oe_n_out <= ext_clk;
      sclk_prev <= sclk_s;
      if (phase != ST_SHIFT) begin
        serial_clock_pin_out <= 1'b1;
      end else if (tick) begin
        serial_clock_pin_out <= ~serial_clock_pin_out;
      end
    end
  end

  // Transfer controller and buffers. The hardware set of rx_full is placed after the read clear and the data write
  // set of tx_full after the load clear, so that an event in the clearing cycle is not lost.
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phase <= ST_IDLE;
      active <= 1'b0;
      shreg <= BYTE_RESET;
      bit_cnt <= 3'h0;
      dummy_stop <= 1'b0;
      tx_buf <= BYTE_RESET;
      tx_full <= 1'b0;
      rx_buf <= BYTE_RESET;
      rx_full <= 1'b0;
      serial_data_out <= SDO_RESET;
      serial_interrupt_out <= 1'b0;
    end else begin
      serial_interrupt_out <= 1'b0;
      if (data_rd) begin
        rx_full <= 1'b0;
      end
      if (control.inhibit) begin
        phase <= ST_IDLE;
        active <= 1'b0;
        bit_cnt <= 3'h0;
        dummy_stop <= 1'b0;
      end else begin
        case (phase)
          ST_IDLE: begin
            if (control.start & mode_ok) begin
              active <= 1'b1;
              phase <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (~control.start) begin
              phase <= ST_IDLE;
              active <= 1'b0;
            end else if (word_ready) begin
              phase <= ST_SHIFT;
              bit_cnt <= 3'h0;
              if (tx_on & tx_full) begin
                shreg <= tx_buf;
                tx_full <= 1'b0;
                serial_interrupt_out <= (control.mode == MODE_TX);
              end else if (tx_on) begin
                shreg <= DUMMY_BYTE;
                dummy_stop <= 1'b1;
              end
            end
          end
          ST_SHIFT: begin
            if (fall_ev & tx_on) begin
              serial_data_out <= shreg[0];
            end
            if (rise_ev) begin
              shreg <= shifted;
              bit_cnt <= bit_cnt + 3'h1;
            end
            if (word_end) begin
              if (rx_on) begin
                rx_buf <= shifted;
                rx_full <= 1'b1;
                serial_interrupt_out <= 1'b1;
              end
              if (~control.start | dummy_stop) begin
                phase <= ST_IDLE;
                active <= 1'b0;
                dummy_stop <= 1'b0;
              end else begin
                phase <= ST_WAIT;
              end
            end
          end
          default: begin
            phase <= ST_IDLE;
            active <= 1'b0;
          end
        endcase
      end
      if (data_wr) begin
        tx_buf <= w_data[7:0];
        tx_full <= 1'b1;
      end
      if (mode_change) begin
        tx_full <= 1'b0;
        rx_full <= 1'b0;
        rx_buf <= BYTE_RESET;
      end
    end
  end

endmodule
`default_nettype wire

// ==== logic/sio_pkg.sv ====
// Package for the clocked synchronous serial I/O block: register map, field layout,
// reset values, mode encodings, the controller state type and the control register struct.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses and one word per register.
package sio_pkg;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_BAUD_IDLE = 8'h0c;

  // Transfer mode select encodings.
  localparam logic [1:0] MODE_TX = 2'h0;
  localparam logic [1:0] MODE_RX = 2'h1;
  localparam logic [1:0] MODE_TXRX = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;

  // Clock select value that picks the external serial clock.
  localparam logic [2:0] CLK_EXTERNAL = 3'h7;

  // Shortest internal half period in peripheral clocks; each select step doubles it.
  localparam logic [7:0] HALF_BASE = 8'h02;

  // Field positions in the status and baud/idle registers.
  localparam int STAT_ACTIVE_BIT = 3;
  localparam int STAT_SHIFT_BIT = 2;
  localparam int IDLE_RUN_BIT = 6;

  // Read-as-one masks for the status and baud/idle registers.
  localparam logic [7:0] STATUS_ONES = 8'hf3;
  localparam logic [7:0] BAUD_IDLE_ONES = 8'hbe;

  // Values after reset, and the index of the last bit of a word.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic IDLE_RUN_RESET = 1'b0;
  localparam logic SDO_RESET = 1'b1;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] BITS_LAST = 3'h7;

  // Byte shifted out when the external clock runs on with no data to send.
  localparam logic [7:0] DUMMY_BYTE = 8'hff;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register one, low byte of its word.
  typedef struct packed {
    logic start;
    logic inhibit;
    logic [1:0] mode;
    logic spare;
    logic [2:0] clk_sel;
  } control_t;

  // Controller phases.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_SHIFT
  } phase_t;

endpackage

// ==== logic/sio_sync.sv ====
// Two-flop synchroniser for pin inputs entering the peripheral clock domain.
// Assumes the inputs change slowly compared with the sampling clock.
`timescale 1ns/1ps
`default_nettype none
module sio_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output var logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule
`default_nettype wire

// ==== tb/sio_assertions.sv ====
// Checker for the serial unit: register bus answers and serial pin timing.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sio_checker
  import sio_pkg::*;
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic awvalid_in,
  input wire logic awready_out,
  input wire logic wvalid_in,
  input wire logic wready_out,
  input wire logic bvalid_out,
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  input wire logic arready_out,
  input wire logic [31:0] rdata_out,
  input wire logic rvalid_out,
  input wire logic rready_in,
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe_n_out,
  input wire logic serial_data_out,
  input wire logic serial_interrupt_out
);
  logic [7:0] ar_q;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // Remember the read address so the answer can be judged against it.
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) ar_q <= 8'h00;
    else if (arvalid_in && arready_out) ar_q <= araddr_in;
  end
  property p_tx_edge;
    !serial_clock_pin_oe_n_out && $changed(serial_data_out) |-> $fell(serial_clock_pin_out);
  endproperty
  a_tx_edge: assert property (p_tx_edge)
    else $error("Serial output moved off a falling edge.");
  property p_rise_hold;
    $rose(serial_clock_pin_out) |=> serial_clock_pin_out;
  endproperty
  a_rise_hold: assert property (p_rise_hold)
    else $error("Serial clock high phase too short.");
  property p_fall_hold;
    $fell(serial_clock_pin_out) |=> !serial_clock_pin_out;
  endproperty
  a_fall_hold: assert property (p_fall_hold)
    else $error("Serial clock low phase too short.");
  property p_irq_pulse;
    serial_interrupt_out |=> !serial_interrupt_out;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("Interrupt longer than one cycle.");
  property p_baud_read;
    rvalid_out && ar_q == ADDR_BAUD_IDLE |-> (rdata_out & 32'hffffffbf) == 32'h000000be;
  endproperty
  a_baud_read: assert property (p_baud_read)
    else $error("Baud idle fixed bits wrong.");
  property p_status_read;
    rvalid_out && ar_q == ADDR_STATUS |-> (rdata_out & 32'hfffffff3) == 32'h000000f3;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("Status fixed bits wrong.");
  property p_rd_hold;
    rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("Read answer dropped early.");
  property p_wr_answer;
    awvalid_in && awready_out && wvalid_in && wready_out |-> ##2 bvalid_out;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("Write answer late.");
endmodule
bind sync_serial_io_mode sio_checker chk_i (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .awvalid_in(awvalid_in),
  .awready_out(awready_out), .wvalid_in(wvalid_in), .wready_out(wready_out), .bvalid_out(bvalid_out),
  .araddr_in(araddr_in), .arvalid_in(arvalid_in), .arready_out(arready_out), .rdata_out(rdata_out),
  .rvalid_out(rvalid_out), .rready_in(rready_in), .serial_clock_pin_out(serial_clock_pin_out),
  .serial_clock_pin_oe_n_out(serial_clock_pin_oe_n_out), .serial_data_out(serial_data_out),
  .serial_interrupt_out(serial_interrupt_out));
`default_nettype wire

// ==== tb/sio_peer.sv ====
// Serial peer: shifts a byte in and out on the pin clock, LSB first.
// Assumes the bench resolves the clock pin and calls ext_word for external frames.
`timescale 1ns/1ps
`default_nettype none
module sio_peer (
  input wire logic sck_in,
  input wire logic so_in,
  input wire logic [7:0] send_in,
  output var logic sck_ext_out,
  output var logic si_out,
  output var logic [7:0] got_out
);
  logic [7:0] sh = 8'h00;
  int nb = 0;
  int words = 0;
  initial sck_ext_out = 1'h1;
  initial si_out = 1'h0;
  initial got_out = 8'h00;
  // The next bit goes out on each falling edge.
  always @(negedge sck_in) si_out <= send_in[nb];
  // Bits are taken on rising edges; eight make a word.
  always @(posedge sck_in) begin
    sh <= {so_in, sh[7:1]};
    if (nb == 7) begin
      got_out <= {so_in, sh[7:1]};
      words <= words + 1;
      nb <= 0;
    end else begin
      nb <= nb + 1;
    end
  end
  // One external word; the clock rests high between frames. The long low phase leaves room for sync delay.
  task automatic ext_word();
    #113;
    repeat (8) begin
      sck_ext_out = 1'h0;
      #300;
      sck_ext_out = 1'h1;
      #100;
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Bench for the serial unit: AXI4-Lite master tasks and one task per scenario.
// Assumes the checker is bound to the design and the peer model sits on the pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sio_pkg::*;
  logic mclk_in = 1'h0;
  logic sys_rst_in = 1'h1;
  logic [7:0] awaddr_in = 8'h00, araddr_in = 8'h00, send = 8'h00, got;
  logic [31:0] wdata_in = 32'h0, rdata_out, rv;
  logic [3:0] wstrb_in = 4'hf;
  logic awvalid_in = 1'h0, wvalid_in = 1'h0, bready_in = 1'h0, arvalid_in = 1'h0, rready_in = 1'h0;
  logic serial_data_in, idle_mode_in = 1'h0, sck_ext;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  logic [1:0] bresp_out, rresp_out, br;
  logic serial_clock_pin_out, serial_clock_pin_oe_n_out, serial_data_out, serial_interrupt_out;
  wire logic serial_clock_pin_in;
  int errors = 0, checked = 0, irqs = 0, falls = 0, cyc = 0;
  // The pin carries our clock only while the unit has let go of it.
  assign serial_clock_pin_in = serial_clock_pin_oe_n_out ? sck_ext : serial_clock_pin_out;
  sync_serial_io_mode dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .awaddr_in(awaddr_in),
    .awvalid_in(awvalid_in), .awready_out(awready_out), .wdata_in(wdata_in), .wstrb_in(wstrb_in),
    .wvalid_in(wvalid_in), .wready_out(wready_out), .bresp_out(bresp_out), .bvalid_out(bvalid_out),
    .bready_in(bready_in), .araddr_in(araddr_in), .arvalid_in(arvalid_in), .arready_out(arready_out),
    .rdata_out(rdata_out), .rresp_out(rresp_out), .rvalid_out(rvalid_out), .rready_in(rready_in),
    .serial_clock_pin_in(serial_clock_pin_in), .serial_clock_pin_out(serial_clock_pin_out),
    .serial_clock_pin_oe_n_out(serial_clock_pin_oe_n_out), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .idle_mode_in(idle_mode_in),
    .serial_interrupt_out(serial_interrupt_out));
  sio_peer peer (.sck_in(serial_clock_pin_in), .so_in(serial_data_out), .send_in(send),
    .sck_ext_out(sck_ext), .si_out(serial_data_in), .got_out(got));
  always #25 mclk_in = ~mclk_in;
  // Count interrupts and cut a hang short well past the expected run length.
  always @(posedge mclk_in) begin
    cyc++;
    if (serial_interrupt_out === 1'h1) irqs++;
    if (cyc == 40000) begin
      errors++;
      finish_test();
    end
  end
  always @(negedge serial_clock_pin_in) falls++;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("FAIL at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Address and data go out together and each drops as soon as it is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, dd;
    @(posedge mclk_in);
    ad = 1'h0;
    dd = 1'h0;
    awaddr_in <= a;
    wdata_in <= d;
    awvalid_in <= 1'h1;
    wvalid_in <= 1'h1;
    bready_in <= 1'h1;
    while (!(ad && dd)) begin
      @(posedge mclk_in);
      if (awvalid_in && awready_out) begin
        ad = 1'h1;
        awvalid_in <= 1'h0;
      end
      if (wvalid_in && wready_out) begin
        dd = 1'h1;
        wvalid_in <= 1'h0;
      end
    end
    while (!bvalid_out) @(posedge mclk_in);
    br = bresp_out;
    bready_in <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_in);
    araddr_in <= a;
    arvalid_in <= 1'h1;
    rready_in <= 1'h1;
    do @(posedge mclk_in); while (!arready_out);
    arvalid_in <= 1'h0;
    while (!rvalid_out) @(posedge mclk_in);
    rv = rdata_out;
    br = rresp_out;
    rready_in <= 1'h0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  task automatic word();
    int w = peer.words;
    while (peer.words == w) @(posedge mclk_in);
  endtask
  // A stopped clock shows no falling edge over many half periods.
  task automatic idle_chk();
    int f = falls;
    repeat (40) @(posedge mclk_in);
    chk(falls, f);
  endtask
  task automatic t_regs();
    rdchk(ADDR_CONTROL, 32'h0);
    rdchk(ADDR_STATUS, 32'hf3);
    rdchk(ADDR_BAUD_IDLE, 32'hbe);
    // Every writable and fixed bit set except bit 0, which software must write as zero.
    wr(ADDR_BAUD_IDLE, 32'hfffffffe);
    rdchk(ADDR_BAUD_IDLE, 32'hfe);
    wr(ADDR_DATA, 32'h5a);
    rdchk(ADDR_DATA, 32'h0);
    wr(8'h40, 32'h1);
    chk(br, RESP_SLVERR);
    rdchk(8'h40, 32'h0);
    chk(br, RESP_SLVERR);
    $display("registers done");
  endtask
  task automatic t_tx();
    int n = irqs;
    wr(ADDR_CONTROL, 32'h42);
    chk(serial_clock_pin_oe_n_out, 32'h0);
    // The pin leaves unknown for high at power-up, which the peer counts as a rise; realign it.
    peer.nb = 0;
    wr(ADDR_DATA, 32'ha5);
    wr(ADDR_CONTROL, 32'h82);
    word();
    chk(got, 32'ha5);
    chk(irqs - n, 32'h1);
    idle_chk();
    rdchk(ADDR_STATUS, 32'hfb);
    wr(ADDR_DATA, 32'h3c);
    wr(ADDR_CONTROL, 32'h02);
    word();
    chk(got, 32'h3c);
    rdchk(ADDR_STATUS, 32'hf3);
    chk(serial_data_out, 32'h0);
    $display("tx internal done");
  endtask
  task automatic t_rx();
    int n = irqs;
    int f;
    wr(ADDR_CONTROL, 32'h52);
    send = 8'h96;
    peer.nb = 0;
    wr(ADDR_CONTROL, 32'h92);
    word();
    idle_chk();
    chk(irqs - n, 32'h1);
    rdchk(ADDR_DATA, 32'h96);
    // Idle with the run bit set keeps the clock going; a hang here ends in the timeout.
    idle_mode_in <= 1'h1;
    f = falls;
    while (falls < f + 3) @(posedge mclk_in);
    wr(ADDR_BAUD_IDLE, 32'h0);
    idle_chk();
    wr(ADDR_CONTROL, 32'h52);
    idle_mode_in <= 1'h0;
    idle_chk();
    rdchk(ADDR_STATUS, 32'hf3);
    $display("rx internal done");
  endtask
  task automatic t_txrx();
    wr(ADDR_CONTROL, 32'h62);
    wr(ADDR_DATA, 32'hc3);
    send = 8'h5a;
    peer.nb = 0;
    wr(ADDR_CONTROL, 32'ha2);
    word();
    chk(got, 32'hc3);
    rdchk(ADDR_DATA, 32'h5a);
    idle_chk();
    send = 8'h77;
    wr(ADDR_DATA, 32'h18);
    wr(ADDR_CONTROL, 32'h22);
    word();
    chk(got, 32'h18);
    rdchk(ADDR_STATUS, 32'hf3);
    wr(ADDR_CONTROL, 32'h42);
    rdchk(ADDR_DATA, 32'h0);
    $display("txrx internal done");
  endtask
  task automatic t_ext();
    wr(ADDR_CONTROL, 32'h47);
    wr(ADDR_DATA, 32'h81);
    peer.nb = 0;
    wr(ADDR_CONTROL, 32'h87);
    chk(serial_clock_pin_oe_n_out, 32'h1);
    peer.ext_word();
    chk(got, 32'h81);
    peer.ext_word();
    chk(got, 32'hff);
    rdchk(ADDR_STATUS, 32'hf3);
    $display("tx external done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Reset for ten cycles, then run every scenario in turn.
  initial begin
    repeat (10) @(posedge mclk_in);
    sys_rst_in <= 1'h0;
    repeat (3) @(posedge mclk_in);
    t_regs();
    t_tx();
    t_rx();
    t_txrx();
    t_ext();
    finish_test();
  end
endmodule
`default_nettype wire
